// ---- inc/amos_pkg.sv ----
/*
  Constants and types for the analog monitor output scaler.
  Assumes a single 100 MHz clock and signed signal inputs in millivolts at base scaling.
*/
package amos_pkg;

  localparam int NCH = 2;

  typedef logic signed [15:0] amos_word_t;
  typedef logic        [7:0]  amos_sel_t;
  typedef logic signed [7:0]  amos_trim_t;

  // Monitor signal selection codes
  localparam amos_sel_t SEL_MOTOR_SPEED = 8'h00;
  localparam amos_sel_t SEL_SPEED_REF   = 8'h01;
  localparam amos_sel_t SEL_TORQUE_REF  = 8'h02;

  // Parameter limits and defaults
  localparam amos_word_t PARAM_MAX      = 16'sh2710;
  localparam amos_word_t PARAM_MIN      = -16'sh2710;
  localparam amos_word_t OFFSET_DEFAULT = 16'sh0000;
  localparam amos_word_t MAG_DEFAULT    = 16'sh0064;

  // Parameter index fields
  localparam logic PKIND_OFFSET = 1'b0;
  localparam logic PKIND_MAG    = 1'b1;

  // Arithmetic scaling, internal unit 0.1 mV
  localparam int SUB_PER_MV      = 10;
  localparam int MAG_DIV         = 100;
  localparam int MAG_SUB_DIV     = MAG_DIV / SUB_PER_MV;
  localparam int OFFSET_STEP_SUB = 1000;
  localparam int GAIN_BASE       = 1000;
  localparam int GAIN_STEP       = 4;
  localparam int OFS_TRIM_STEP   = 189;

  // Trim kinds and limits
  localparam logic       TKIND_OFFSET  = 1'b0;
  localparam logic       TKIND_GAIN    = 1'b1;
  localparam amos_trim_t OFS_TRIM_MAX  = 8'sh7f;
  localparam amos_trim_t GAIN_TRIM_MAX = 8'sh7d;
  localparam amos_trim_t TRIM_ZERO     = 8'sh00;

  // DAC code range in millivolts
  localparam int DAC_MAX = 32767;

endpackage

// ---- src/amos_trim_store.sv ----
/*
  Trim store: per-channel offset and gain trims, kept apart from the parameter set.
  Assumes writes come as single-cycle strobes from the adjustment path.
*/
`timescale 1ns/1ps
module amos_trim_store #(
  parameter amos_pkg::amos_trim_t FACTORY_OFS_TRIM  = 8'sh00,
  parameter amos_pkg::amos_trim_t FACTORY_GAIN_TRIM = 8'sh00
) (
  input  wire logic                             mclk,
  input  wire logic                             resetn,
  input  wire logic                             trim_write,
  input  wire logic                             trim_channel,
  input  wire logic                             trim_kind,
  input  wire amos_pkg::amos_trim_t             trim_wdata,
  input  wire logic                             write_prohibit,
  output logic      [amos_pkg::NCH-1:0][7:0]    offset_trim,
  output logic      [amos_pkg::NCH-1:0][7:0]    gain_trim
);
  import amos_pkg::*;

  typedef struct packed {
    logic [NCH-1:0][7:0] ofs;
    logic [NCH-1:0][7:0] gain;
  } amos_trim_state_t;

  amos_trim_state_t s;
  amos_trim_state_t next_s;

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_s = s;
    if (trim_write && !write_prohibit) begin
      if (trim_kind == TKIND_OFFSET) begin
        if (trim_wdata > OFS_TRIM_MAX) begin // RQ5
          next_s.ofs[trim_channel] = OFS_TRIM_MAX;
        end else if (trim_wdata < -OFS_TRIM_MAX) begin
          next_s.ofs[trim_channel] = -OFS_TRIM_MAX;
        end else begin
          next_s.ofs[trim_channel] = trim_wdata;
        end
      end else begin
        if (trim_wdata > GAIN_TRIM_MAX) begin // RQ6
          next_s.gain[trim_channel] = GAIN_TRIM_MAX;
        end else if (trim_wdata < -GAIN_TRIM_MAX) begin
          next_s.gain[trim_channel] = -GAIN_TRIM_MAX;
        end else begin
          next_s.gain[trim_channel] = trim_wdata;
        end
      end
    end
  end

  // Factory values at reset; no parameter restore reaches here
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s <= {{NCH{FACTORY_OFS_TRIM}}, {NCH{FACTORY_GAIN_TRIM}}}; // RQ9 RQ8
    end else begin
      s <= next_s;
    end
  end

  assign offset_trim = s.ofs;
  assign gain_trim   = s.gain;

  ////////////////////////////////////////////////////////////////////////////////
  a_prohibit_hold: assert property (@(posedge mclk) disable iff (!resetn) // RQ10
    write_prohibit |=> $stable(offset_trim) && $stable(gain_trim))
    else $error("trim changed while writes prohibited");

endmodule

// ---- src/amos_scaler.sv ----
/*
  Two-channel analog monitor output scaler: select, magnify, offset, negate, trim, saturate.
  Assumes signal inputs are signed millivolts at base scaling, synchronous to mclk.
*/
`timescale 1ns/1ps
// Overview of operation
// RQ1: Each channel outputs minus the sum of selected signal times magnification and offset.
// RQ2: Each channel has an offset in 0.1 V steps, range +-10000, default 0, effective at once.
// RQ3: Each channel has a magnification in 0.01 steps, range +-10000, default 100, at once.
// RQ4: Offset and gain trims apply when motor speed or torque reference is selected.
// RQ5: The offset trim shifts the zero point by 18.9 mV per step within +-2.4 V.
// RQ6: The gain trim scales the output from 50 to 150 percent in 0.4 percent steps.
// RQ7: Effective gain in percent is 100 plus trim times 0.4, zero trim giving unity.
// RQ8: Trims live outside the parameter set and survive a parameter restore.
// RQ9: Trims start at factory-calibrated values.
// RQ10: The operator checks that parameter writing is not prohibited before trimming.
// RQ11: The operator trims offset with a known zero signal selected.
// RQ12: Magnification 100 gives base scaling and 1000 gives ten times it.
// RQ13: The selection code picks the signal: 00 motor speed, 01 speed ref, 02 torque ref.
// RQ14: Each output saturates to the DAC range instead of wrapping.
module amos_scaler #(
  parameter amos_pkg::amos_trim_t FACTORY_OFS_TRIM  = 8'sh00,
  parameter amos_pkg::amos_trim_t FACTORY_GAIN_TRIM = 8'sh00
) (
  input  wire logic                 mclk,
  input  wire logic                 resetn,
  input  wire amos_pkg::amos_word_t motor_speed,
  input  wire amos_pkg::amos_word_t speed_reference,
  input  wire amos_pkg::amos_word_t torque_reference,
  input  wire amos_pkg::amos_sel_t  monitor1_signal_select,
  input  wire amos_pkg::amos_sel_t  monitor2_signal_select,
  input  wire logic                 param_write,
  input  wire logic [1:0]           param_index,
  input  wire amos_pkg::amos_word_t param_wdata,
  input  wire logic                 param_init,
  input  wire logic                 trim_write,
  input  wire logic                 trim_channel,
  input  wire logic                 trim_kind,
  input  wire amos_pkg::amos_trim_t trim_wdata,
  input  wire logic                 write_prohibit,
  output amos_pkg::amos_word_t      dac1_code,
  output amos_pkg::amos_word_t      dac2_code
);
  import amos_pkg::*;

  typedef struct packed {
    logic [NCH-1:0][15:0] off;
    logic [NCH-1:0][15:0] mag;
    logic [NCH-1:0][31:0] raw;
    logic [NCH-1:0]       trim_on;
    logic [NCH-1:0][15:0] dac;
  } amos_state_t;

  amos_state_t          s;
  amos_state_t          next_s;
  logic [NCH-1:0][7:0]  sel_vec;
  logic [NCH-1:0][7:0]  offset_trim;
  logic [NCH-1:0][7:0]  gain_trim;
  longint               sig_calc  [NCH];
  longint               raw_calc  [NCH];
  longint               trim_calc [NCH];
  longint               mv_calc   [NCH];

  assign sel_vec = {monitor2_signal_select, monitor1_signal_select};

  ////////////////////////////////////////////////////////////////////////////////
  function automatic amos_word_t amos_clamp(input amos_word_t v);
    if (v > PARAM_MAX) begin
      return PARAM_MAX;
    end else if (v < PARAM_MIN) begin
      return PARAM_MIN;
    end
    return v;
  endfunction

  function automatic longint amos_pick(input amos_sel_t sel);
    unique case (sel)
      SEL_MOTOR_SPEED: amos_pick = longint'(motor_speed);      // RQ13
      SEL_SPEED_REF:   amos_pick = longint'(speed_reference);
      SEL_TORQUE_REF:  amos_pick = longint'(torque_reference);
      default:         amos_pick = 0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  amos_trim_store #(
    .FACTORY_OFS_TRIM  (FACTORY_OFS_TRIM),
    .FACTORY_GAIN_TRIM (FACTORY_GAIN_TRIM)
  ) u_trim (
    .mclk           (mclk),
    .resetn         (resetn),
    .trim_write     (trim_write),
    .trim_channel   (trim_channel),
    .trim_kind      (trim_kind),
    .trim_wdata     (trim_wdata),
    .write_prohibit (write_prohibit),
    .offset_trim    (offset_trim),
    .gain_trim      (gain_trim)
  );

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_s = s;
    if (param_init) begin
      for (int c = 0; c < NCH; c++) begin
        next_s.off[c] = OFFSET_DEFAULT; // RQ2
        next_s.mag[c] = MAG_DEFAULT;    // RQ3
      end
    end else if (param_write) begin
      if (param_index[1] == PKIND_MAG) begin
        next_s.mag[param_index[0]] = amos_clamp(param_wdata); // RQ3
      end else begin
        next_s.off[param_index[0]] = amos_clamp(param_wdata); // RQ2
      end
    end
    for (int c = 0; c < NCH; c++) begin
      // Stage one: negated magnified sum in 0.1 mV
      sig_calc[c] = amos_pick(sel_vec[c]);
      raw_calc[c] = -((sig_calc[c] * longint'($signed(s.mag[c]))) / MAG_SUB_DIV // RQ1 RQ12
                    + longint'($signed(s.off[c])) * OFFSET_STEP_SUB);
      next_s.raw[c]     = raw_calc[c][31:0];
      next_s.trim_on[c] = (sel_vec[c] == SEL_MOTOR_SPEED) || (sel_vec[c] == SEL_TORQUE_REF); // RQ4
      // Stage two: trims, then millivolts and saturation
      if (s.trim_on[c]) begin
        trim_calc[c] = longint'($signed(s.raw[c]))
                       * (GAIN_BASE + GAIN_STEP * longint'($signed(gain_trim[c]))) // RQ7 RQ6
                       / GAIN_BASE
                       + longint'($signed(offset_trim[c])) * OFS_TRIM_STEP;        // RQ5
      end else begin
        trim_calc[c] = longint'($signed(s.raw[c]));
      end
      mv_calc[c] = trim_calc[c] / SUB_PER_MV;
      if (mv_calc[c] > DAC_MAX) begin // RQ14
        mv_calc[c] = DAC_MAX;
      end else if (mv_calc[c] < -DAC_MAX) begin
        mv_calc[c] = -DAC_MAX;
      end
      next_s.dac[c] = mv_calc[c][15:0];
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s <= '{off: {NCH{OFFSET_DEFAULT}}, mag: {NCH{MAG_DEFAULT}}, default: '0};
    end else begin
      s <= next_s;
    end
  end

  assign dac1_code = s.dac[0];
  assign dac2_code = s.dac[1];

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  logic ch0_plain;
  logic ch0_notrim;
  assign ch0_plain = (monitor1_signal_select == SEL_MOTOR_SPEED) && $signed(s.off[0]) == 0
                     && $signed(offset_trim[0]) == 0
                     && !param_write && !param_init && !trim_write;
  assign ch0_notrim = (monitor1_signal_select == 8'h03) && !param_write && !param_init;

  a_unity_follow: assert property ( // RQ12
    (ch0_plain && $signed(s.mag[0]) == 100 && $signed(gain_trim[0]) == 0 && $stable(motor_speed)
     && motor_speed < 16'sh2000 && motor_speed > -16'sh2000) [*3]
    |-> int'($signed(dac1_code)) == -int'($past(motor_speed, 2)))
    else $error("unity magnification does not follow negated signal");

  a_tenfold_mag: assert property ( // RQ12
    (ch0_plain && $signed(s.mag[0]) == 1000 && $signed(gain_trim[0]) == 0 && $stable(motor_speed)
     && motor_speed < 16'sh0bb8 && motor_speed > -16'sh0bb8) [*3]
    |-> int'($signed(dac1_code)) == -10 * int'($past(motor_speed, 2)))
    else $error("magnification 1000 is not tenfold");

  a_offset_volts: assert property ( // RQ2
    (ch0_notrim && $signed(s.off[0]) < 300 && $signed(s.off[0]) > -300) [*3]
    |-> int'($signed(dac1_code)) == -100 * int'($signed(s.off[0])))
    else $error("offset voltage not applied in 0.1 V steps");

  a_trim_gated: assert property ( // RQ4
    (ch0_notrim && $signed(s.off[0]) == 0) [*3] |-> $signed(dac1_code) == 0)
    else $error("trim applied to an untrimmed signal");

  a_gain_trim: assert property ( // RQ7
    (ch0_plain && $signed(s.mag[0]) == 100 && motor_speed == 16'sh03e8
     && $stable(gain_trim[0])) [*3]
    |-> int'($signed(dac1_code)) == -(1000 + 4 * int'($signed(gain_trim[0]))))
    else $error("gain trim not 0.4 percent per step");

  a_offset_trim: assert property ( // RQ5
    ((monitor1_signal_select == SEL_TORQUE_REF) && torque_reference == 0
     && $signed(s.off[0]) == 0 && $stable(offset_trim[0]) && !param_write
     && !param_init) [*3]
    |-> int'($signed(dac1_code)) == int'($signed(offset_trim[0])) * 189 / 10)
    else $error("offset trim not 18.9 mV per step");

  a_dac_saturate: assert property ( // RQ14
    (!s.trim_on[0] && $signed(s.raw[0]) > 327679) |=> int'($signed(dac1_code)) == DAC_MAX)
    else $error("output wrapped instead of saturating");

  a_param_defaults: assert property ( // RQ3
    param_init |=> $signed(s.mag[0]) == 100 && $signed(s.mag[1]) == 100
                   && s.off[0] == 0 && s.off[1] == 0)
    else $error("parameter restore did not give defaults");

  a_param_clamp: assert property ( // RQ3
    (param_write && !param_init && param_index == 2'h2 && param_wdata > 16'sh2710)
    |=> $signed(s.mag[0]) == 10000)
    else $error("magnification not held within range");

  a_trim_kept: assert property ( // RQ8
    (param_init && !trim_write) |=> $stable(offset_trim) && $stable(gain_trim))
    else $error("trims changed by parameter restore");

  a_select_ref: assert property ( // RQ13
    ((monitor2_signal_select == SEL_SPEED_REF) && $signed(s.mag[1]) == 100
     && s.off[1] == 0 && $stable(speed_reference) && !param_write && !param_init
     && speed_reference < 16'sh2000 && speed_reference > -16'sh2000) [*3]
    |-> int'($signed(dac2_code)) == -int'($past(speed_reference, 2)))
    else $error("speed reference not selected by code 01");

  c_unity: cover property (
    (ch0_plain && $signed(s.mag[0]) == 100 && motor_speed != 0) [*3]);
  c_saturate: cover property (int'($signed(dac1_code)) == DAC_MAX);
  c_restore: cover property (param_init ##1 $signed(s.mag[0]) == 100);
  c_gain_trimmed: cover property (s.trim_on[0] && $signed(gain_trim[0]) != 0);

endmodule

// ---- test/amos_recorder.sv ----
/*
  Measuring instrument model: records both monitor outputs on request.
  Assumes a trigger pulse from the bench, synchronous to mclk; it only
  watches the outputs and never drives the scaler.
*/
`timescale 1ns/1ps
module amos_recorder (
  input  wire logic                 mclk,
  input  wire logic                 resetn,
  input  wire logic                 trig,
  input  wire amos_pkg::amos_word_t dac1_code,
  input  wire amos_pkg::amos_word_t dac2_code,
  output amos_pkg::amos_word_t      rec1,
  output amos_pkg::amos_word_t      rec2,
  output logic                      got
);
  import amos_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Capture of both channels
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rec1 <= 16'sh0000;
      rec2 <= 16'sh0000;
      got  <= 1'b0;
    end else begin
      got <= trig;
      if (trig) begin
        rec1 <= dac1_code;
        rec2 <= dac2_code;
      end
    end
  end
endmodule

// ---- test/tb_amos_scaler.sv ----
/*
  Self-checking bench for the monitor output scaler.
  Assumes the recorder model and the package; factory trims are set non-zero.
*/
`timescale 1ns/1ps
module tb_amos_scaler;
  import amos_pkg::*;
  localparam amos_trim_t F_OT = 8'sh05;
  localparam amos_trim_t F_GT = -8'sh0a;
  logic       mclk = 1'b0, resetn = 1'b0, param_write = 1'b0, param_init = 1'b0;
  logic       trim_write = 1'b0, trim_channel = 1'b0, trim_kind = 1'b0;
  logic       write_prohibit = 1'b0, trig = 1'b0, got;
  logic [1:0] param_index = 2'h0;
  amos_word_t motor_speed = 16'sh0000, speed_reference = 16'sh0000;
  amos_word_t torque_reference = 16'sh0000, param_wdata = 16'sh0000;
  amos_word_t dac1_code, dac2_code, rec1, rec2;
  amos_sel_t  monitor1_signal_select = 8'h00, monitor2_signal_select = 8'h00;
  amos_trim_t trim_wdata = 8'sh00;
  int         miscompares = 0, num_checks = 0, seed = 32'hc8c3;
  longint     mag[2] = '{100, 100}, off[2] = '{0, 0}, ot[2] = '{5, 5}, gt[2] = '{-10, -10};
  amos_word_t q[$];

  amos_scaler #(.FACTORY_OFS_TRIM(F_OT), .FACTORY_GAIN_TRIM(F_GT)) DUT (.mclk(mclk),
    .resetn(resetn), .motor_speed(motor_speed), .speed_reference(speed_reference),
    .torque_reference(torque_reference), .monitor1_signal_select(monitor1_signal_select),
    .monitor2_signal_select(monitor2_signal_select), .param_write(param_write),
    .param_index(param_index), .param_wdata(param_wdata), .param_init(param_init),
    .trim_write(trim_write), .trim_channel(trim_channel), .trim_kind(trim_kind),
    .trim_wdata(trim_wdata), .write_prohibit(write_prohibit), .dac1_code(dac1_code),
    .dac2_code(dac2_code));
  amos_recorder rec (.mclk(mclk), .resetn(resetn), .trig(trig), .dac1_code(dac1_code),
    .dac2_code(dac2_code), .rec1(rec1), .rec2(rec2), .got(got));

  ////////////////////////////////////////////////////////////////////////
  // Expected output of one channel
  function automatic amos_word_t model(input int ch);
    longint s, r, t;
    amos_sel_t sel;
    sel = ch ? monitor2_signal_select : monitor1_signal_select;
    s = (sel == SEL_MOTOR_SPEED) ? motor_speed : (sel == SEL_SPEED_REF) ? speed_reference :
        (sel == SEL_TORQUE_REF) ? torque_reference : 0;
    r = -(s * mag[ch] / 10 + off[ch] * 1000);
    t = (sel == SEL_MOTOR_SPEED || sel == SEL_TORQUE_REF) ?
        r * (1000 + 4 * gt[ch]) / 1000 + ot[ch] * 189 : r;
    t = t / 10;
    if (t > DAC_MAX) t = DAC_MAX;
    if (t < -DAC_MAX) t = -DAC_MAX;
    return amos_word_t'(t);
  endfunction

  task automatic check(input amos_word_t seen, input amos_word_t exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %0d expected %0d", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    if (miscompares == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic sample;
    repeat (3) @(posedge mclk);
    q.push_back(model(0));
    q.push_back(model(1));
    trig <= 1'b1;
    @(posedge mclk) trig <= 1'b0;
  endtask

  task automatic setp(input logic [1:0] i, input longint v);
    @(posedge mclk);
    param_write <= 1'b1;
    param_index <= i;
    param_wdata <= amos_word_t'(v);
    @(posedge mclk) param_write <= 1'b0;
    v = (v > 10000) ? 10000 : (v < -10000) ? -10000 : v;
    if (i[1]) mag[i[0]] = v;
    else off[i[0]] = v;
  endtask

  task automatic sett(input int ch, input logic k, input longint v);
    longint lim;
    @(posedge mclk);
    trim_write <= 1'b1;
    trim_channel <= ch[0];
    trim_kind <= k;
    trim_wdata <= amos_trim_t'(v);
    @(posedge mclk) trim_write <= 1'b0;
    v = longint'(amos_trim_t'(v));
    lim = k ? 125 : 127;
    v = (v > lim) ? lim : (v < -lim) ? -lim : v;
    if (write_prohibit === 1'b0 && k) gt[ch] = v;
    else if (write_prohibit === 1'b0) ot[ch] = v;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Clock, result watcher, watchdog
  initial forever #5 mclk = ~mclk;
  always @(posedge mclk) begin
    if (got === 1'b1) begin
      check(rec1, q.pop_front());
      check(rec2, q.pop_front());
    end
  end
  initial begin
    #500000;
    miscompares++;
    end_sim();
  end

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (10) @(posedge mclk);
    resetn <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      @(posedge mclk);
      motor_speed <= amos_word_t'($random(seed));
      speed_reference <= amos_word_t'($random(seed));
      torque_reference <= amos_word_t'($random(seed));
      monitor1_signal_select <= amos_sel_t'(s);
      monitor2_signal_select <= amos_sel_t'(3 - s);
      sample();
    end
    @(posedge mclk) monitor1_signal_select <= SEL_MOTOR_SPEED;
    motor_speed <= 16'sh03e8;
    setp(2'h2, 1000);
    sample();
    setp(2'h0, -25);
    setp(2'h1, 12000);
    setp(2'h3, -15000);
    sample();
    sett(0, TKIND_GAIN, -125);
    sample();
    sett(0, TKIND_GAIN, 125);
    sample();
    @(posedge mclk) monitor1_signal_select <= SEL_SPEED_REF;
    sample();
    @(posedge mclk) torque_reference <= 16'sh0000;
    monitor2_signal_select <= SEL_TORQUE_REF;
    sett(1, TKIND_OFFSET, 127);
    sample();
    sett(1, TKIND_OFFSET, -128);
    sample();
    @(posedge mclk) write_prohibit <= 1'b1;
    sett(1, TKIND_GAIN, 60);
    sample();
    @(posedge mclk) write_prohibit <= 1'b0;
    param_init <= 1'b1;
    @(posedge mclk) param_init <= 1'b0;
    mag = '{100, 100};
    off = '{0, 0};
    sample();
    @(posedge mclk) monitor1_signal_select <= SEL_MOTOR_SPEED;
    sett(0, TKIND_OFFSET, 0);
    sett(0, TKIND_GAIN, 0);
    sample();
    setp(2'h2, 12000);
    setp(2'h2, 1000);
    sample();
    @(posedge mclk) monitor1_signal_select <= SEL_TORQUE_REF;
    sett(0, TKIND_OFFSET, -40);
    sample();
    for (int n = 0; n < 24; n++) begin
      @(posedge mclk);
      motor_speed <= amos_word_t'($random(seed));
      speed_reference <= amos_word_t'($random(seed));
      torque_reference <= amos_word_t'($random(seed));
      monitor1_signal_select <= amos_sel_t'($unsigned($random(seed)) % 4);
      monitor2_signal_select <= amos_sel_t'($unsigned($random(seed)) % 4);
      setp(2'($unsigned($random(seed)) % 4), $random(seed) % 11000);
      sett(n % 2, n[1], $random(seed) % 130);
      sample();
    end
    repeat (3) @(posedge mclk);
    end_sim();
  end
endmodule
